// ===== logic/aiops_port.sv
// Addressable 8-bit I/O port with AHB-Lite registers and capture FIFO.
`timescale 1ns/1ps
`include "aiops_regs.svh"

module aiops_fifo #(
   parameter int WIDTH = `AIOPS_BYTE_W,
   parameter int DEPTH = `AIOPS_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Filling side.
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             full;
   logic             empty;

   assign empty       = (wr_ptr == rd_ptr);
   assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
                        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clock_i) begin
      if (in_valid_i && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
      end else if (in_valid_i && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ptr <= '0;
      end else if (out_ready_i && !empty) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

module aiops_port #(
   parameter aiops_pkg::aiops_byte_t ADDR_LOW_MATCH = `AIOPS_ADDR_LOW_RST
) (
   // Clock and reset.
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   // Host side controls.
   input  wire logic                   bus_gate_n_i,
   input  wire logic                   select_strobe_i,
   input  wire logic                   write_strobe_i,
   input  wire logic                   latch_clk_i,
   // Host side bus, active low, two-way.
   input  wire aiops_pkg::aiops_byte_t host_bus_n_i,
   output aiops_pkg::aiops_byte_t      host_bus_n_o,
   output logic                        host_bus_oe_o,
   // User side controls.
   input  wire logic                   user_write_n_i,
   input  wire logic                   user_read_n_i,
   // User side bus, two-way.
   input  wire aiops_pkg::aiops_byte_t user_bus_i,
   output aiops_pkg::aiops_byte_t      user_bus_o,
   output logic                        user_bus_oe_o,
   // Capture back-pressure.
   output logic                        capture_ready_o,
   // AHB-Lite slave.
   input  wire logic                   hsel_i,
   input  wire logic [31:0]            haddr_i,
   input  wire logic [1:0]             htrans_i,
   input  wire logic                   hwrite_i,
   input  wire logic [2:0]             hsize_i,
   input  wire logic                   hready_i,
   input  wire aiops_pkg::aiops_word_t hwdata_i,
   output aiops_pkg::aiops_word_t      hrdata_o,
   output logic                        hreadyout_o,
   output logic                        hresp_o
);
   import aiops_pkg::*;

   aiops_byte_t data_latch;
   aiops_byte_t user_view;
   aiops_byte_t next_latch;
   aiops_byte_t fifo_head;
   aiops_ctrl_t ctrl;
   logic        selected;
   logic        gate;
   logic        addr_match;
   logic        addr_cycle;
   logic        host_wr;
   logic        user_wr;
   logic        latch_wr;
   logic        fifo_valid;
   logic        fifo_pop;
   logic        overflow;
   logic        ahb_go;
   logic        dp_wr;
   logic [7:0]  dp_addr;

   // Host side is qualified by the bus gate only; user side never is.
   assign gate       = !bus_gate_n_i;
   assign addr_match = ((host_bus_n_i ^ ADDR_LOW_MATCH) ==
                        `AIOPS_ADDR_ONES);
   assign addr_cycle = gate && latch_clk_i && select_strobe_i;
   // Data store needs select, except when both strobes are high.
   assign host_wr    = gate && latch_clk_i && write_strobe_i &&
                       user_write_n_i &&
                       (select_strobe_i || selected);
   assign user_wr    = !user_write_n_i &&
                       (!ctrl[`AIOPS_CTRL_SYNC] || latch_clk_i);
   assign latch_wr   = host_wr || user_wr;

   // The latch holds host polarity; user writes are stored inverted.
   always_comb begin
      next_latch = data_latch;
      if (user_wr) begin
         next_latch = ~user_bus_i;
      end else if (host_wr) begin
         next_latch = host_bus_n_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_latch <= `AIOPS_LATCH_RST;
         user_view  <= ~`AIOPS_LATCH_RST;
      end else begin
         data_latch <= next_latch;
         user_view  <= ~next_latch;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         selected <= 1'b0;
      end else if (addr_cycle) begin
         selected <= addr_match;
      end
   end

   assign host_bus_n_o  = data_latch;
   assign host_bus_oe_o = gate && !select_strobe_i &&
                          !write_strobe_i && selected;
   assign user_bus_o    = user_view;
   assign user_bus_oe_o = !user_read_n_i && user_write_n_i;

   // Every latch update is queued for software when capture is enabled and the FIFO is not full.
   aiops_fifo #(
      .WIDTH (`AIOPS_BYTE_W),
      .DEPTH (`AIOPS_FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (latch_wr && ctrl[`AIOPS_CTRL_CAPEN]),
      .in_ready_o  (capture_ready_o),
      .in_data_i   (next_latch),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_head)
   );

   // AHB-Lite slave: zero wait states, read data registered in address phase.
   assign ahb_go      = hsel_i && hready_i && htrans_i[1];
   assign fifo_pop    = ahb_go && !hwrite_i &&
                        (haddr_i[7:0] == `AIOPS_OFS_FIFO);
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dp_wr   <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr   <= ahb_go && hwrite_i;
         dp_addr <= haddr_i[7:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= `AIOPS_CTRL_RST;
      end else if (dp_wr && dp_addr == `AIOPS_OFS_CTRL) begin
         ctrl <= hwdata_i[1:0];
      end
   end

   // A lost capture sets overflow; the set wins over a software clear.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow <= 1'b0;
      end else if (latch_wr && ctrl[`AIOPS_CTRL_CAPEN] &&
                   !capture_ready_o) begin
         overflow <= 1'b1;
      end else if (dp_wr && dp_addr == `AIOPS_OFS_STATUS &&
                   hwdata_i[`AIOPS_ST_OVERFLOW]) begin
         overflow <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_o <= `AIOPS_WORD_ZERO;
      end else if (ahb_go && !hwrite_i) begin
         case (haddr_i[7:0])
            `AIOPS_OFS_CTRL: begin
               hrdata_o <= {30'h00000000, ctrl};
            end
            `AIOPS_OFS_STATUS: begin
               hrdata_o <= {28'h0000000, overflow, !capture_ready_o,
                            !fifo_valid, selected};
            end
            `AIOPS_OFS_LATCH: begin
               hrdata_o <= {24'h000000, data_latch};
            end
            `AIOPS_OFS_FIFO: begin
               hrdata_o <= fifo_valid ? {24'h000000, fifo_head}
                                      : `AIOPS_WORD_ZERO;
            end
            default: begin
               hrdata_o <= `AIOPS_WORD_ZERO;
            end
         endcase
      end
   end

   // Checks.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_host_out_needs_sel;
      host_bus_oe_o |-> selected && gate;
   endproperty
   a_host_out_needs_sel: assert property (p_host_out_needs_sel)
      else $error("Host bus driven while not selected.");

   property p_both_strobes_store;
      gate && latch_clk_i && select_strobe_i && write_strobe_i &&
      user_write_n_i |=> data_latch == $past(host_bus_n_i);
   endproperty
   a_both_strobes_store: assert property (p_both_strobes_store)
      else $error("Combined cycle did not store the word.");

   property p_select_follows_match;
      addr_cycle |=> selected == $past(addr_match);
   endproperty
   a_select_follows_match: assert property (p_select_follows_match)
      else $error("Select latch does not follow address compare.");

   property p_user_sees_inverted;
      host_wr |=> user_bus_o == ~$past(host_bus_n_i);
   endproperty
   a_user_sees_inverted: assert property (p_user_sees_inverted)
      else $error("User side not inverted after host write.");

   property p_user_readback;
      user_wr |=> user_bus_o == $past(user_bus_i) &&
                  host_bus_n_o == ~$past(user_bus_i);
   endproperty
   a_user_readback: assert property (p_user_readback)
      else $error("User write read back wrongly.");

   property p_match_rule;
      addr_cycle && host_bus_n_i == ~ADDR_LOW_MATCH |=> selected;
   endproperty
   a_match_rule: assert property (p_match_rule)
      else $error("Programmed address failed to select.");

   property p_gate_blocks;
      bus_gate_n_i && !user_wr |=> $stable(data_latch) && $stable(selected);
   endproperty
   a_gate_blocks: assert property (p_gate_blocks)
      else $error("Host side acted with bus gate inactive.");

   // A host data write attempted in the same cycle must lose to the user.
   property p_user_priority;
      user_wr && gate && latch_clk_i && write_strobe_i |=>
         data_latch == ~$past(user_bus_i);
   endproperty
   a_user_priority: assert property (p_user_priority)
      else $error("User write lost priority.");

   property p_write_unselected;
      !selected && !select_strobe_i && !user_wr |=> $stable(data_latch);
   endproperty
   a_write_unselected: assert property (p_write_unselected)
      else $error("Unselected write strobe changed the latch.");

   property p_sync_clock;
      ctrl[`AIOPS_CTRL_SYNC] && !latch_clk_i && !host_wr |=>
         $stable(data_latch);
   endproperty
   a_sync_clock: assert property (p_sync_clock)
      else $error("Sync variant loaded with clock low.");

   property p_user_out_free;
      !user_read_n_i && user_write_n_i |-> user_bus_oe_o;
   endproperty
   a_user_out_free: assert property (p_user_out_free)
      else $error("User read blocked.");

   c_select: cover property (addr_cycle && addr_match ##1 host_bus_oe_o);
   c_combined: cover property (select_strobe_i && write_strobe_i && host_wr);
   c_full: cover property (!capture_ready_o);
   c_overflow: cover property ($rose(overflow));
endmodule

// ===== common/aiops_regs.svh
// Register offsets, field positions and reset values of the I/O port.
`ifndef AIOPS_REGS_SVH
`define AIOPS_REGS_SVH

`define AIOPS_OFS_CTRL     8'h00
`define AIOPS_OFS_STATUS   8'h04
`define AIOPS_OFS_LATCH    8'h08
`define AIOPS_OFS_FIFO     8'h0C

`define AIOPS_CTRL_SYNC    0
`define AIOPS_CTRL_CAPEN   1
`define AIOPS_CTRL_RST     2'h3

`define AIOPS_ST_SELECTED  0
`define AIOPS_ST_EMPTY     1
`define AIOPS_ST_FULL      2
`define AIOPS_ST_OVERFLOW  3

`define AIOPS_LATCH_RST    8'h00
`define AIOPS_ADDR_ONES    8'hFF
`define AIOPS_ADDR_LOW_RST 8'h00
`define AIOPS_FIFO_DEPTH   32
`define AIOPS_BYTE_W       8
`define AIOPS_WORD_ZERO    32'h00000000

`endif

// ===== common/aiops_pkg.sv
// Types shared by the addressable I/O port files.
package aiops_pkg;
   typedef logic [7:0]  aiops_byte_t;
   typedef logic [31:0] aiops_word_t;
   typedef logic [1:0]  aiops_ctrl_t;
endpackage

// ===== tb/aiops_host_model.sv
// Processor-side controller model that drives the port's host bus pins.
`timescale 1ns/1ps
module aiops_host_model (
   // Clock.
   input  wire logic              clock_i,
   // Host bus pins.
   output logic                   bus_gate_n_o,
   output logic                   select_strobe_o,
   output logic                   write_strobe_o,
   output logic                   latch_clk_o,
   output aiops_pkg::aiops_byte_t bus_n_o
);
   import aiops_pkg::*;
   initial begin
      bus_gate_n_o = 1'b1;
      select_strobe_o = 1'b0;
      write_strobe_o = 1'b0;
      latch_clk_o = 1'b0;
      bus_n_o = 8'h00;
   end
   // Holds one cycle of controls, then releases them and drives the bus to the inverted word.
   task automatic op(input logic g_n, ss, ws, lc, input aiops_byte_t w);
      @(posedge clock_i);
      bus_gate_n_o <= g_n;
      select_strobe_o <= ss;
      write_strobe_o <= ws;
      latch_clk_o <= lc;
      bus_n_o <= w;
      @(posedge clock_i);
      bus_gate_n_o <= 1'b1;
      select_strobe_o <= 1'b0;
      write_strobe_o <= 1'b0;
      latch_clk_o <= 1'b0;
      bus_n_o <= ~w;
   endtask
endmodule

// ===== tb/tb_addressable_io_port_select.sv
// Self-checking bench for the addressable I/O port.
`timescale 1ns/1ps
module tb_addressable_io_port_select;
   import aiops_pkg::*;
   localparam logic [5:0] ROWS [9] = '{6'h0E, 6'h37, 6'h17, 6'h0E, 6'h1E,
                                        6'h1F, 6'h0C, 6'h20, 6'h24};
   logic        clock_i, rst_n_i, uw_n, ur_n, hsel, hwrite;
   logic        hoe, uoe, crdy, hrdy, hresp;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   aiops_word_t hwdata, hrd;
   aiops_byte_t ub, hbo, ubo, hb_m;
   wire         g_n, ss, ws, lc;
   wire [7:0]   hb_w, ub_w;
   int          bad_count, total_checks, cycles, lat, sync_m, cap_m, ovf, sel;
   int          q[$];
   assign hb_w = hoe ? hbo : hb_m;
   assign ub_w = uoe ? ubo : ub;
   aiops_host_model host_u (.clock_i(clock_i), .bus_gate_n_o(g_n),
      .select_strobe_o(ss), .write_strobe_o(ws), .latch_clk_o(lc),
      .bus_n_o(hb_m));
   aiops_port #(.ADDR_LOW_MATCH(8'h5A)) dut_u (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .bus_gate_n_i(g_n), .select_strobe_i(ss),
      .write_strobe_i(ws), .latch_clk_i(lc), .host_bus_n_i(hb_w),
      .host_bus_n_o(hbo), .host_bus_oe_o(hoe), .user_write_n_i(uw_n),
      .user_read_n_i(ur_n), .user_bus_i(ub_w), .user_bus_o(ubo),
      .user_bus_oe_o(uoe), .capture_ready_o(crdy), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hready_i(hrdy), .hwdata_i(hwdata), .hrdata_o(hrd),
      .hreadyout_o(hrdy), .hresp_o(hresp));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic ahb(logic w, logic [31:0] a, d, output logic [31:0] r);
      @(posedge clock_i);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clock_i);
      while (hrdy !== 1'b1) @(posedge clock_i);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock_i);
      while (hrdy !== 1'b1) @(posedge clock_i);
      r = hrd;
      chk("hresp", 32'h0, hresp);
   endtask
   // Control word is {gate_n, select, write, latch clock, user write_n, match}.
   task automatic step(logic [5:0] c);
      aiops_byte_t w, u;
      logic hw, uw, ho, ro;
      logic [31:0] r;
      w = c[0] ? 8'hA5 : aiops_byte_t'($urandom);
      if (!c[0] && w == 8'hA5) w = 8'h00;
      u = aiops_byte_t'($urandom);
      ro = 1'($urandom);
      ho = !c[5] && !c[4] && !c[3] && sel != 0;
      hw = !c[5] && c[2] && c[3] && c[1] && (c[4] || sel != 0);
      uw = !c[1] && (sync_m == 0 || c[2]);
      if (!c[5] && c[2] && c[4]) sel = int'(w == 8'hA5);
      if (uw) lat = 255 - u;
      else if (hw) lat = w;
      if ((uw || hw) && cap_m != 0) begin
         if (q.size() < 32) q.push_back(lat);
         else ovf = 1;
      end
      fork
         host_u.op(c[5], c[4], c[3], c[2], w);
         begin
            @(posedge clock_i);
            uw_n <= c[1];
            ub <= u;
            ur_n <= ro;
            @(negedge clock_i);
            chk("host_oe", ho, hoe);
            chk("user_oe", !ro && c[1], uoe);
            @(posedge clock_i);
            uw_n <= 1'b1;
            ub <= ~u;
         end
      join
      @(negedge clock_i);
      chk("host_out", lat, hbo);
      chk("user_out", 255 - lat, ubo);
      chk("capture_ready", q.size() < 32, crdy);
      ahb(1'b0, 32'h4, 32'h0, r);
      chk("status", ovf * 8 + (q.size() == 32) * 4 + (q.size() == 0) * 2 + sel,
          r);
   endtask
   initial begin
      logic [31:0] r;
      rst_n_i = 1'b0;
      {uw_n, hsel} = 2'b11;
      {ur_n, hwrite, htrans, haddr, hwdata, ub} = '0;
      hsize = 3'h2;
      sync_m = 1;
      cap_m = 1;
      void'($urandom(85));
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(negedge clock_i);
      chk("host_reset", 32'h0, hbo);
      chk("user_reset", 32'hFF, ubo);
      ahb(1'b0, 32'h0, 32'h0, r);
      chk("ctrl", 32'h3, r);
      foreach (ROWS[i]) step(ROWS[i]);
      ahb(1'b1, 32'h0, 32'h2, r);
      sync_m = 0;
      repeat (60) step(6'($urandom));
      repeat (33) step(6'h20);
      ahb(1'b0, 32'h8, 32'h0, r);
      chk("latch", lat, r);
      ahb(1'b0, 32'h10, 32'h0, r);
      chk("unmapped", 32'h0, r);
      ahb(1'b1, 32'h4, 32'h8, r);
      ovf = 0;
      while (q.size() > 0) begin
         ahb(1'b0, 32'hC, 32'h0, r);
         chk("fifo", q.pop_front(), r);
      end
      ahb(1'b0, 32'hC, 32'h0, r);
      chk("fifo_empty", 32'h0, r);
      ahb(1'b0, 32'h4, 32'h0, r);
      chk("status_end", sel + 2, r);
      wrap_up();
   end
endmodule
